/* fbu_pkg.sv */
`default_nettype none
package fbu_pkg;
	// Line control register layout
	localparam int LC_WIDTH = 10;
	localparam int LC_ENABLE_POS = 0;
	localparam int LC_EOT_POS = 4;
	localparam int LC_HSE_POS = 5;
	localparam int LC_TX_EN_POS = 8;
	localparam int LC_RX_EN_POS = 9;
	localparam logic [9:0] LC_RESET = 10'h300;
	// Frame format register layout
	localparam int FF_WIDTH = 8;
	localparam int FF_BREAK_POS = 0;
	localparam int FF_PAR_EN_POS = 1;
	localparam int FF_EVEN_POS = 2;
	localparam int FF_STOP2_POS = 3;
	localparam int FF_WLEN_LSB = 5;
	localparam int FF_STICK_POS = 7;
	// Divisor and shadow register
	localparam int BAUD_INT_WIDTH = 16;
	localparam int BAUD_FRAC_WIDTH = 6;
	localparam int DIV_REG_WIDTH = 30;
	localparam logic [29:0] DIV_REG_RESET = 30'h0000_0000;
	// Oversampling: last tick index of a bit and of half a bit
	localparam int OSR_X16 = 16;
	localparam int OSR_X8 = 8;
	localparam logic [3:0] BIT_LAST_X16 = 4'hF;
	localparam logic [3:0] BIT_LAST_X8 = 4'h7;
	localparam logic [3:0] HALF_LAST_X16 = 4'h7;
	localparam logic [3:0] HALF_LAST_X8 = 4'h3;
	localparam int RX_TIMEOUT_BITS = 32;
	// Data path
	localparam int DATA_WIDTH = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int ST_WIDTH = 4;
	localparam int ST_FE = 0;
	localparam int ST_PE = 1;
	localparam int ST_BE = 2;
	localparam int ST_OE = 3;
	// Event bit positions
	localparam int EV_WIDTH = 7;
	localparam int EV_RX = 0;
	localparam int EV_TX = 1;
	localparam int EV_RT = 2;
	localparam int EV_FE = 3;
	localparam int EV_PE = 4;
	localparam int EV_BE = 5;
	localparam int EV_OE = 6;
	// FIFO level select codes
	localparam logic [2:0] LVL_1_8 = 3'h0;
	localparam logic [2:0] LVL_1_4 = 3'h1;
	localparam logic [2:0] LVL_1_2 = 3'h2;
	localparam logic [2:0] LVL_3_4 = 3'h3;
	localparam logic [2:0] LVL_7_8 = 3'h4;
	// Serial frame phases, shared by both directions
	typedef enum logic [2:0] {PH_IDLE, PH_START, PH_DATA, PH_PARITY, PH_STOP} fbu_phase_type;
endpackage
`default_nettype wire

/* fbu_uart.sv */
`timescale 1ns/100ps
`default_nettype none

module fbu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = fbu_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [CW-1:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Full refuses writes even when a read happens in the same cycle
	assign in_ready = count != CW'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	assign level = count;

	// Pointers wrap naturally, so depth must be a power of two
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'h1;
			if (pop)
				rd_ptr <= rd_ptr + 1'h1;
			count <= count + CW'(push) - CW'(pop);
		end
	end

	// Storage has no reset, only the pointers matter
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule

module fbu_uart #(
	parameter int FIFO_DEPTH = fbu_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// Line control register
	input wire logic [fbu_pkg::LC_WIDTH-1:0] LINE_CTRL_DATA,
	input wire logic LINE_CTRL_WR,
	output logic [fbu_pkg::LC_WIDTH-1:0] LINE_CTRL_Q,
	// Divisors and frame format
	input wire logic [fbu_pkg::BAUD_INT_WIDTH-1:0] BAUD_INT_DIVISOR,
	input wire logic [fbu_pkg::BAUD_FRAC_WIDTH-1:0] BAUD_FRAC_DIVISOR,
	input wire logic [fbu_pkg::FF_WIDTH-1:0] FRAME_FORMAT_DATA,
	input wire logic FRAME_FORMAT_WR,
	// FIFO level selects
	input wire logic [2:0] TX_LEVEL_SELECT,
	input wire logic [2:0] RX_LEVEL_SELECT,
	// Events
	input wire logic [fbu_pkg::EV_WIDTH-1:0] IRQ_MASK_BITS,
	input wire logic [fbu_pkg::EV_WIDTH-1:0] IRQ_CLEAR,
	output logic [fbu_pkg::EV_WIDTH-1:0] RAW_IRQ_STATUS,
	output logic [fbu_pkg::EV_WIDTH-1:0] MASKED_IRQ_STATUS,
	output logic IRQ,
	// Transmit stream
	input wire logic [fbu_pkg::DATA_WIDTH-1:0] TX_DATA,
	input wire logic TX_VALID,
	output logic TX_READY,
	// Receive stream
	output logic [fbu_pkg::DATA_WIDTH-1:0] RX_DATA,
	output logic [fbu_pkg::ST_WIDTH-1:0] RX_STATUS,
	output logic RX_VALID,
	input wire logic RX_READY,
	// Status and serial lines
	output logic BUSY,
	input wire logic SERIAL_RX_LINE,
	output logic SERIAL_TX_LINE
);
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam int RXW = fbu_pkg::DATA_WIDTH + fbu_pkg::ST_WIDTH;
	localparam logic [9:0] RT_LAST_X16 = 10'(fbu_pkg::RX_TIMEOUT_BITS * fbu_pkg::OSR_X16 - 1);
	localparam logic [9:0] RT_LAST_X8 = 10'(fbu_pkg::RX_TIMEOUT_BITS * fbu_pkg::OSR_X8 - 1);

	// Threshold in entries for a level select code
	function automatic logic [CW-1:0] level_threshold(input logic [2:0] sel);
		logic [CW-1:0] thr;
		thr = CW'(FIFO_DEPTH / 2);
		case (sel)
			fbu_pkg::LVL_1_8: thr = CW'(FIFO_DEPTH / 8);
			fbu_pkg::LVL_1_4: thr = CW'(FIFO_DEPTH / 4);
			fbu_pkg::LVL_1_2: thr = CW'(FIFO_DEPTH / 2);
			fbu_pkg::LVL_3_4: thr = CW'(FIFO_DEPTH * 3 / 4);
			fbu_pkg::LVL_7_8: thr = CW'(FIFO_DEPTH * 7 / 8);
			default: thr = CW'(FIFO_DEPTH / 2);
		endcase
		return thr;
	endfunction

	// Parity of a character, with stick parity forcing a constant
	function automatic logic parity_bit(input logic [7:0] d, input logic even, input logic stick);
		logic p;
		p = even ? ^d : ~^d;
		if (stick)
			p = ~even;
		return p;
	endfunction

	default clocking chk_cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	// Line control register, both direction enables set but the module enable clear out of reset
	logic [fbu_pkg::LC_WIDTH-1:0] line_ctrl;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			line_ctrl <= fbu_pkg::LC_RESET;
		else if (LINE_CTRL_WR)
			line_ctrl <= LINE_CTRL_DATA;
	end
	assign LINE_CTRL_Q = line_ctrl;
	wire module_en = line_ctrl[fbu_pkg::LC_ENABLE_POS];
	wire eot_sel = line_ctrl[fbu_pkg::LC_EOT_POS];
	wire high_speed_bit = line_ctrl[fbu_pkg::LC_HSE_POS];
	wire tx_go = module_en && line_ctrl[fbu_pkg::LC_TX_EN_POS];
	wire rx_go = module_en && line_ctrl[fbu_pkg::LC_RX_EN_POS];

	// Shadow of divisors and frame format; divisor writes wait for a frame-format write
	logic [fbu_pkg::DIV_REG_WIDTH-1:0] div_reg;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			div_reg <= fbu_pkg::DIV_REG_RESET;
		else if (FRAME_FORMAT_WR)
			div_reg <= {BAUD_INT_DIVISOR, BAUD_FRAC_DIVISOR, FRAME_FORMAT_DATA};
	end
	wire [15:0] div_int = div_reg[29:14];
	wire [5:0] div_frac = div_reg[13:8];
	wire [7:0] fmt = div_reg[7:0];
	wire send_break = fmt[fbu_pkg::FF_BREAK_POS];
	wire par_en = fmt[fbu_pkg::FF_PAR_EN_POS];
	wire par_even = fmt[fbu_pkg::FF_EVEN_POS];
	wire stop2 = fmt[fbu_pkg::FF_STOP2_POS];
	wire par_stick = fmt[fbu_pkg::FF_STICK_POS];
	wire [1:0] wlen = fmt[fbu_pkg::FF_WLEN_LSB+1:fbu_pkg::FF_WLEN_LSB];
	wire [2:0] nbits_last = {1'h0, wlen} + 3'h4;
	wire [7:0] len_mask = 8'hFF >> (2'h3 - wlen);

	// Oversampling selection: 16 ticks a bit normally, 8 in high-speed mode
	wire [3:0] bit_last = high_speed_bit ? fbu_pkg::BIT_LAST_X8 : fbu_pkg::BIT_LAST_X16;
	wire [3:0] half_last = high_speed_bit ? fbu_pkg::HALF_LAST_X8 : fbu_pkg::HALF_LAST_X16;
	wire [9:0] rt_last = high_speed_bit ? RT_LAST_X8 : RT_LAST_X16;

	// Fractional reference generator: period alternates int and int+1 by fraction carry
	logic [15:0] baud_cnt;
	logic [5:0] frac_acc;
	wire gen_run = div_int != 16'h0000;
	wire ref_tick = gen_run && baud_cnt == 16'h0000;
	wire [6:0] frac_sum = {1'h0, frac_acc} + {1'h0, div_frac};
	wire [15:0] reload = div_int - 16'h0001 + {15'h0000, frac_sum[6]};
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			baud_cnt <= 16'h0000;
			frac_acc <= 6'h00;
		end else if (!gen_run) begin
			baud_cnt <= 16'h0000;
			frac_acc <= 6'h00;
		end else if (ref_tick) begin
			baud_cnt <= reload;
			frac_acc <= frac_sum[5:0];
		end else begin
			baud_cnt <= baud_cnt - 16'h0001;
		end
	end

	// Transmit FIFO; the shifter's load strobe doubles as its pop
	wire tx_load;
	wire [7:0] tx_word;
	wire tx_pop_valid;
	wire [CW-1:0] tx_level;
	fbu_fifo #(.WIDTH(fbu_pkg::DATA_WIDTH), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clk(CORE_CLK),
		.rst(RST),
		.in_valid(TX_VALID),
		.in_ready(TX_READY),
		.in_data(TX_DATA),
		.out_valid(tx_pop_valid),
		.out_ready(tx_load),
		.out_data(tx_word),
		.level(tx_level)
	);

	// Transmit shifter
	fbu_pkg::fbu_phase_type tx_phase;
	logic [3:0] tx_cnt;
	logic [2:0] tx_idx;
	logic [7:0] tx_shift;
	logic tx_par;
	logic tx_stop2nd;
	logic tx_line;
	assign tx_load = tx_phase == fbu_pkg::PH_IDLE && tx_go && tx_pop_valid;
	wire [7:0] tx_masked = tx_word & len_mask;
	// A disable only blocks the next load; the running frame always completes
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			tx_phase <= fbu_pkg::PH_IDLE;
			tx_cnt <= 4'h0;
			tx_idx <= 3'h0;
			tx_shift <= 8'h00;
			tx_par <= 1'h0;
			tx_stop2nd <= 1'h0;
		end else if (tx_load) begin
			tx_phase <= fbu_pkg::PH_START;
			tx_cnt <= 4'h0;
			tx_idx <= 3'h0;
			tx_shift <= tx_masked;
			tx_par <= parity_bit(tx_masked, par_even, par_stick);
			tx_stop2nd <= 1'h0;
		end else if (ref_tick && tx_phase != fbu_pkg::PH_IDLE) begin
			tx_cnt <= tx_cnt + 4'h1;
			if (tx_cnt == bit_last) begin
				tx_cnt <= 4'h0;
				unique case (tx_phase)
					fbu_pkg::PH_IDLE: ;
					fbu_pkg::PH_START: tx_phase <= fbu_pkg::PH_DATA;
					fbu_pkg::PH_DATA: begin
						tx_shift <= tx_shift >> 1;
						tx_idx <= tx_idx + 3'h1;
						if (tx_idx == nbits_last)
							tx_phase <= par_en ? fbu_pkg::PH_PARITY : fbu_pkg::PH_STOP;
					end
					fbu_pkg::PH_PARITY: tx_phase <= fbu_pkg::PH_STOP;
					fbu_pkg::PH_STOP: begin
						if (stop2 && !tx_stop2nd)
							tx_stop2nd <= 1'h1;
						else
							tx_phase <= fbu_pkg::PH_IDLE;
					end
				endcase
			end
		end
	end

	// Line level per phase; break holds the line low
	wire next_tx_line = send_break ? 1'h0 :
		tx_phase == fbu_pkg::PH_START ? 1'h0 :
		tx_phase == fbu_pkg::PH_DATA ? tx_shift[0] :
		tx_phase == fbu_pkg::PH_PARITY ? tx_par : 1'h1;
	wire busy_now = tx_pop_valid || tx_phase != fbu_pkg::PH_IDLE;
	logic busy_q;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			tx_line <= 1'h1;
			busy_q <= 1'h0;
		end else begin
			tx_line <= next_tx_line;
			busy_q <= busy_now;
		end
	end
	assign SERIAL_TX_LINE = tx_line;
	assign BUSY = busy_q;
	wire busy_fall = busy_q && !busy_now;

	// Receive sampler; line is synchronous to the core clock already
	fbu_pkg::fbu_phase_type rx_phase;
	logic [3:0] rx_cnt;
	logic [2:0] rx_idx;
	logic [7:0] rx_shift;
	logic rx_pe;
	logic rx_ones;
	logic rx_high;
	wire rx_line = SERIAL_RX_LINE;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rx_phase <= fbu_pkg::PH_IDLE;
			rx_cnt <= 4'h0;
			rx_idx <= 3'h0;
			rx_shift <= 8'h00;
			rx_pe <= 1'h0;
			rx_ones <= 1'h0;
			rx_high <= 1'h1;
		end else if (ref_tick) begin
			rx_high <= rx_line;
			rx_cnt <= rx_cnt + 4'h1;
			unique case (rx_phase)
				fbu_pkg::PH_IDLE: begin
					// Needs a high-to-low edge, so a held break cannot retrigger
					if (rx_go && rx_high && !rx_line) begin
						rx_phase <= fbu_pkg::PH_START;
						rx_cnt <= 4'h0;
					end
				end
				fbu_pkg::PH_START: begin
					if (rx_cnt == half_last) begin
						rx_cnt <= 4'h0;
						rx_phase <= rx_line ? fbu_pkg::PH_IDLE : fbu_pkg::PH_DATA;
						rx_idx <= 3'h0;
						rx_shift <= 8'h00;
						rx_pe <= 1'h0;
						rx_ones <= 1'h0;
					end
				end
				fbu_pkg::PH_DATA: begin
					if (rx_cnt == bit_last) begin
						rx_cnt <= 4'h0;
						rx_shift[rx_idx] <= rx_line;
						rx_ones <= rx_ones | rx_line;
						rx_idx <= rx_idx + 3'h1;
						if (rx_idx == nbits_last)
							rx_phase <= par_en ? fbu_pkg::PH_PARITY : fbu_pkg::PH_STOP;
					end
				end
				fbu_pkg::PH_PARITY: begin
					if (rx_cnt == bit_last) begin
						rx_cnt <= 4'h0;
						rx_pe <= rx_line != parity_bit(rx_shift, par_even, par_stick);
						rx_ones <= rx_ones | rx_line;
						rx_phase <= fbu_pkg::PH_STOP;
					end
				end
				fbu_pkg::PH_STOP: begin
					if (rx_cnt == bit_last) begin
						rx_cnt <= 4'h0;
						rx_phase <= fbu_pkg::PH_IDLE;
					end
				end
			endcase
		end
	end

	// Character completion and status assembly
	wire rx_done = ref_tick && rx_phase == fbu_pkg::PH_STOP && rx_cnt == bit_last;
	wire rx_fe = !rx_line;
	wire rx_be = !rx_line && !rx_ones;
	logic oe_pend;
	logic [fbu_pkg::ST_WIDTH-1:0] rx_status;
	always_comb begin
		rx_status = '0;
		rx_status[fbu_pkg::ST_FE] = rx_fe;
		rx_status[fbu_pkg::ST_PE] = rx_pe;
		rx_status[fbu_pkg::ST_BE] = rx_be;
		rx_status[fbu_pkg::ST_OE] = oe_pend;
	end
	wire rx_in_ready;
	wire [RXW-1:0] rx_out_word;
	wire rx_out_valid;
	wire [CW-1:0] rx_level;
	wire rx_push_ok = rx_done && rx_in_ready;
	wire rx_overrun = rx_done && !rx_in_ready;
	wire rx_pop = rx_out_valid && RX_READY;
	fbu_fifo #(.WIDTH(RXW), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.clk(CORE_CLK),
		.rst(RST),
		.in_valid(rx_done),
		.in_ready(rx_in_ready),
		.in_data({rx_status, rx_shift}),
		.out_valid(rx_out_valid),
		.out_ready(RX_READY),
		.out_data(rx_out_word),
		.level(rx_level)
	);
	assign RX_DATA = rx_out_word[fbu_pkg::DATA_WIDTH-1:0];
	assign RX_STATUS = rx_out_word[RXW-1:fbu_pkg::DATA_WIDTH];
	assign RX_VALID = rx_out_valid;

	// A lost character is reported on the next one that fits
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			oe_pend <= 1'h0;
		else if (rx_overrun)
			oe_pend <= 1'h1;
		else if (rx_push_ok)
			oe_pend <= 1'h0;
	end

	// Receive timeout counts reference ticks with data waiting and no traffic
	logic [9:0] rt_cnt;
	wire rx_activity = rx_push_ok || rx_pop;
	wire rt_fire = ref_tick && rx_out_valid && !rx_activity && rt_cnt == rt_last - 10'h001;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			rt_cnt <= 10'h000;
		else if (!rx_out_valid || rx_activity)
			rt_cnt <= 10'h000;
		else if (ref_tick && rt_cnt != rt_last)
			rt_cnt <= rt_cnt + 10'h001;
	end

	// Level crossings are edge events so a steady level does not refire after clear
	wire tx_lvl_hit = tx_level <= level_threshold(TX_LEVEL_SELECT);
	wire rx_lvl_hit = rx_level >= level_threshold(RX_LEVEL_SELECT);
	logic tx_lvl_d;
	logic rx_lvl_d;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			tx_lvl_d <= 1'h1;
			rx_lvl_d <= 1'h0;
		end else begin
			tx_lvl_d <= tx_lvl_hit;
			rx_lvl_d <= rx_lvl_hit;
		end
	end

	// Event sources
	logic [fbu_pkg::EV_WIDTH-1:0] ev_set;
	always_comb begin
		ev_set = '0;
		ev_set[fbu_pkg::EV_RX] = rx_lvl_hit && !rx_lvl_d;
		ev_set[fbu_pkg::EV_TX] = eot_sel ? busy_fall : tx_lvl_hit && !tx_lvl_d;
		ev_set[fbu_pkg::EV_RT] = rt_fire;
		ev_set[fbu_pkg::EV_FE] = rx_done && rx_fe;
		ev_set[fbu_pkg::EV_PE] = rx_done && rx_pe;
		ev_set[fbu_pkg::EV_BE] = rx_done && rx_be;
		ev_set[fbu_pkg::EV_OE] = rx_overrun;
	end

	// Raw status: a set in the clearing cycle wins
	logic [fbu_pkg::EV_WIDTH-1:0] raw;
	wire [fbu_pkg::EV_WIDTH-1:0] empty_clr = rx_out_valid ? 7'h00 : 7'h01 << fbu_pkg::EV_RT;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			raw <= '0;
		else
			raw <= (raw & ~(IRQ_CLEAR | empty_clr)) | ev_set;
	end
	assign RAW_IRQ_STATUS = raw;
	assign MASKED_IRQ_STATUS = raw & IRQ_MASK_BITS;
	assign IRQ = |MASKED_IRQ_STATUS;

	chk_busy_fifo: assert property (tx_pop_valid |=> BUSY)
		else $error("busy low while transmit fifo holds data");
	chk_busy_shifter: assert property (!BUSY |-> $past(tx_phase) == fbu_pkg::PH_IDLE)
		else $error("busy low while shifter active");
	chk_start_low: assert property (tx_phase == fbu_pkg::PH_START && !send_break
		|=> !SERIAL_TX_LINE)
		else $error("start bit not driven low");
	chk_div_hold: assert property (!FRAME_FORMAT_WR |=> $stable(div_reg))
		else $error("divisor shadow changed without frame-format write");
	chk_ref_gap: assert property (ref_tick && reload != 16'h0000 |=> !ref_tick)
		else $error("reference tick period too short");
	chk_start_reject: assert property (rx_phase == fbu_pkg::PH_START && ref_tick
		&& rx_cnt == half_last && rx_line |=> rx_phase == fbu_pkg::PH_IDLE)
		else $error("false start bit accepted");
	chk_clear_event: assert property (IRQ_CLEAR[fbu_pkg::EV_FE] && !ev_set[fbu_pkg::EV_FE]
		|=> !RAW_IRQ_STATUS[fbu_pkg::EV_FE])
		else $error("framing event survived clear");
	chk_set_wins: assert property (ev_set[fbu_pkg::EV_OE] |=> RAW_IRQ_STATUS[fbu_pkg::EV_OE])
		else $error("overrun event lost");
	chk_irq_masked: assert property ((RAW_IRQ_STATUS & IRQ_MASK_BITS) == 7'h00 |-> !IRQ)
		else $error("request raised by masked event");
	chk_rt_empty: assert property (!rx_out_valid |=> !RAW_IRQ_STATUS[fbu_pkg::EV_RT])
		else $error("timeout event with empty receive fifo");
	chk_frame_stop: assert property (rx_done && !rx_line |-> ev_set[fbu_pkg::EV_FE])
		else $error("framing error not flagged");

	cov_tx_done: cover property (busy_fall);
	cov_rx_char: cover property (rx_push_ok && !rx_fe);
	cov_rx_timeout: cover property (rt_fire);
	cov_overrun: cover property (rx_overrun);
endmodule
`default_nettype wire

/* fbu_peer.sv */
`timescale 1ns/100ps
`default_nettype none
module fbu_peer (
	// Clock
	input wire logic clk,
	// Serial lines seen from the far side
	input wire logic tx_line,
	output logic rx_line
);
	// Line idles high between frames
	initial rx_line = 1'b1;

	// Drive one frame of eight data bits, no parity; a low stop bit forces a framing fault
	task automatic send(input logic [7:0] d, input logic stop, input int bitc);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		@(negedge clk);
		for (int i = 0; i < 10; i++) begin
			rx_line = f[i];
			repeat (bitc) @(negedge clk);
		end
		rx_line = 1'b1;
	endtask

	// Short low pulse that a receiver must not take for a start bit
	task automatic glitch(input int len);
		@(negedge clk);
		rx_line = 1'b0;
		repeat (len) @(negedge clk);
		rx_line = 1'b1;
	endtask

	// Catch one frame, sampling mid-bit; ok is low on a bad start or stop or a timeout
	// Sampled on the falling edge, where the registered transmit line has settled
	task automatic recv(input int bitc, output logic [7:0] d, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		d = 8'h00;
		while (tx_line !== 1'b0 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		if (n < 4000) begin
			repeat (bitc / 2) @(negedge clk);
			ok = (tx_line === 1'b0);
			for (int i = 0; i < 8; i++) begin
				repeat (bitc) @(negedge clk);
				d[i] = tx_line;
			end
			repeat (bitc) @(negedge clk);
			ok = ok & (tx_line === 1'b1);
		end
	endtask
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk, rst, lc_wr, ff_wr, tx_valid, rx_ready, ser_rx, ser_tx;
	logic tx_ready, rx_valid, irq, busy, ok;
	logic [9:0] lc_data, lc_q;
	logic [15:0] baud_int;
	logic [7:0] tx_data, rx_data, d;
	logic [6:0] mask, clr, raw, msk;
	logic [3:0] rx_st;
	logic [5:0] frac;
	logic [7:0] fmt;
	logic [2:0] rx_sel;
	int num_errors, n_compared, n;

	fbu_uart dut (.CORE_CLK(clk), .RST(rst), .LINE_CTRL_DATA(lc_data), .LINE_CTRL_WR(lc_wr),
		.LINE_CTRL_Q(lc_q), .BAUD_INT_DIVISOR(baud_int), .BAUD_FRAC_DIVISOR(frac),
		.FRAME_FORMAT_DATA(fmt), .FRAME_FORMAT_WR(ff_wr), .TX_LEVEL_SELECT(3'h0),
		.RX_LEVEL_SELECT(rx_sel), .IRQ_MASK_BITS(mask), .IRQ_CLEAR(clr), .RAW_IRQ_STATUS(raw),
		.MASKED_IRQ_STATUS(msk), .IRQ(irq), .TX_DATA(tx_data), .TX_VALID(tx_valid),
		.TX_READY(tx_ready), .RX_DATA(rx_data), .RX_STATUS(rx_st), .RX_VALID(rx_valid),
		.RX_READY(rx_ready), .BUSY(busy), .SERIAL_RX_LINE(ser_rx), .SERIAL_TX_LINE(ser_tx));
	fbu_peer peer (.clk(clk), .tx_line(ser_tx), .rx_line(ser_rx));

	// 25 MHz core clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic lc_write(input logic [9:0] v);
		@(negedge clk);
		lc_data = v;
		lc_wr = 1'b1;
		@(negedge clk);
		lc_wr = 1'b0;
	endtask

	task automatic push(input logic [7:0] v);
		@(negedge clk);
		tx_data = v;
		tx_valid = 1'b1;
		@(negedge clk);
		tx_valid = 1'b0;
	endtask

	// Wait for the receive head, compare it with its status, optionally pop it
	// Leading edge keeps a second pop from raising ready in the step the first lowered it
	task automatic pop(input logic [11:0] exp, input logic take);
		n = 0;
		@(negedge clk);
		while (rx_valid !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		if (n >= 400) begin
			num_errors++;
			summarize();
		end else begin
			check("rx char", {rx_st, rx_data}, exp);
			if (take) begin
				rx_ready = 1'b1;
				@(negedge clk);
				rx_ready = 1'b0;
			end
		end
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		summarize();
	end

	initial begin
		rst = 1'b1;
		{lc_wr, ff_wr, tx_valid, rx_ready} = 4'h0;
		lc_data = 10'h300;
		baud_int = 16'h0001;
		frac = 6'h00;
		fmt = 8'h60;
		rx_sel = 3'h0;
		tx_data = 8'h00;
		mask = 7'h00;
		clr = 7'h00;
		num_errors = 0;
		n_compared = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		check("line ctrl reset", lc_q, 10'h300);
		check("idle busy line", {busy, ser_tx}, 2'h1);
		// Load the shadow while disabled, then change the divisor without reloading
		ff_wr = 1'b1;
		@(negedge clk);
		ff_wr = 1'b0;
		baud_int = 16'h0002;
		// Fill the transmit buffer while disabled until it refuses
		n = 0;
		while (tx_ready === 1'b1 && n < 20) begin
			tx_data = 8'h30 + 8'(n);
			tx_valid = 1'b1;
			@(negedge clk);
			n++;
		end
		tx_valid = 1'b0;
		check("tx depth", 16'(n), 16'h0010);
		check("busy disabled", busy, 1'b1);
		lc_write(10'h301);
		for (int i = 0; i < 16; i++) begin
			peer.recv(16, d, ok);
			check("tx frame", {ok, d}, {1'b1, 8'h30 + 8'(i)});
		end
		n = 0;
		while (busy !== 1'b0 && n < 200) begin
			@(negedge clk);
			n++;
		end
		check("busy end", {busy, raw[fbu_pkg::EV_TX]}, 2'h1);
		// Disable in mid-character
		push(8'hA6);
		fork
			peer.recv(16, d, ok);
			begin
				repeat (60) @(negedge clk);
				lc_write(10'h300);
			end
		join
		check("tx finish", {ok, d}, 9'h1A6);
		// High-speed oversampling halves the bit
		lc_write(10'h320);
		lc_write(10'h321);
		push(8'h4B);
		peer.recv(8, d, ok);
		check("tx x8", {ok, d}, 9'h14B);
		lc_write(10'h300);
		lc_write(10'h301);
		// Receive two characters back to back
		peer.send(8'hA5, 1'b1, 16);
		peer.send(8'h5A, 1'b1, 16);
		check("rx level", raw[fbu_pkg::EV_RX], 1'b1);
		pop(12'h0A5, 1'b1);
		pop(12'h05A, 1'b1);
		peer.glitch(3);
		repeat (300) @(negedge clk);
		check("glitch", rx_valid, 1'b0);
		// Framing fault, masking, clearing, timeout
		peer.send(8'h3C, 1'b0, 16);
		pop(12'h13C, 1'b0);
		check("fe raw", {irq, raw[fbu_pkg::EV_FE]}, 2'h1);
		mask = 7'h08;
		@(negedge clk);
		check("fe masked", {irq, msk}, 8'h88);
		clr = 7'h08;
		@(negedge clk);
		clr = 7'h00;
		@(negedge clk);
		check("fe cleared", {irq, raw[fbu_pkg::EV_FE]}, 2'h0);
		repeat (600) @(negedge clk);
		check("timeout set", raw[fbu_pkg::EV_RT], 1'b1);
		pop(12'h13C, 1'b1);
		@(negedge clk);
		check("timeout gone", raw[fbu_pkg::EV_RT], 1'b0);
		peer.send(8'h00, 1'b0, 16);
		pop(12'h500, 1'b1);
		// Fill the receive buffer past full against the seven-eighths level
		rx_sel = 3'h4;
		clr = 7'h01;
		@(negedge clk);
		clr = 7'h00;
		for (int i = 0; i < 13; i++)
			peer.send(8'h11, 1'b1, 16);
		check("rx below 7/8", raw[fbu_pkg::EV_RX], 1'b0);
		for (int i = 0; i < 4; i++)
			peer.send(8'h11, 1'b1, 16);
		check("rx full overrun", {raw[fbu_pkg::EV_OE], raw[fbu_pkg::EV_RX]}, 2'h3);
		for (int i = 0; i < 16; i++)
			pop(12'h011, 1'b1);
		peer.send(8'h22, 1'b1, 16);
		pop(12'h822, 1'b1);
		// Even parity, divisor 2.5, transmit event on end of transmission
		lc_write(10'h300);
		frac = 6'h20;
		fmt = 8'h66;
		ff_wr = 1'b1;
		clr = 7'h02;
		@(negedge clk);
		ff_wr = 1'b0;
		clr = 7'h00;
		lc_write(10'h311);
		push(8'h01);
		peer.recv(40, d, ok);
		check("tx parity frac", {ok, d, raw[fbu_pkg::EV_TX]}, 10'h202);
		n = 0;
		while (busy !== 1'b0 && n < 200) begin
			@(negedge clk);
			n++;
		end
		check("eot event", {busy, raw[fbu_pkg::EV_TX]}, 2'h1);
		peer.send(8'h01, 1'b0, 40);
		pop(12'h201, 1'b1);
		summarize();
	end
endmodule
`default_nettype wire
